// ==== pkg/dmd_pkg.sv ====
package dmd_pkg;

	// ****************************************
	// Bus map
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_WREGS = 8'h08;
	localparam logic [7:0] OFS_ICLOAD = 8'h0c;
	localparam int CTRL_RUN_BIT = 0;
	localparam int CTRL_STEP_BIT = 1;
	localparam int STAT_PTR_LSB = 16;
	localparam int STAT_CARRY_BIT = 30;
	localparam int STAT_BUSY_BIT = 31;

	// ****************************************
	// Reset values and timing
	// ****************************************
	localparam logic [9:0] IC_RST = 10'h000;
	localparam logic [8:0] PTR_RST = 9'h000;
	localparam int DELAY_MS = 40;
	localparam int CLK_KHZ = 20000;
	localparam int DELAY_CYCLES_DEF = DELAY_MS * CLK_KHZ;

	// ****************************************
	// Opcode fields
	// ****************************************
	localparam logic [1:0] ID_KEEP = 2'h0;
	localparam logic [1:0] ID_INC = 2'h1;
	localparam logic [1:0] ID_DEC = 2'h2;
	localparam logic [1:0] ID_REG = 2'h3;
	localparam logic [3:0] OP_B2M = 4'h1;
	localparam logic [3:0] OP_M2B = 4'h2;
	localparam logic [3:0] OP_ADC = 4'h3;
	localparam logic [3:0] OP_OR = 4'h4;
	localparam logic [3:0] OP_XOR = 4'h5;
	localparam logic [3:0] OP_ADD = 4'h6;
	localparam logic [3:0] OP_AND = 4'h7;
	localparam logic [7:0] OP_CTRL1 = 8'hec;
	localparam logic [7:0] OP_CTRL1_CLR = 8'hed;
	localparam logic [7:0] OP_CTRL2 = 8'hfc;
	localparam logic [7:0] OP_AUX_DATA = 8'h8c;
	localparam logic [7:0] OP_AUX_WORK = 8'h8d;

	typedef struct packed {
		logic [9:0] ic;
		logic [8:0] ptr;
		logic [3:0][7:0] wreg;
		logic carry;
		logic run;
		logic stepReq;
		logic [19:0] delayCnt;
		logic delayBusy;
		logic ramWrEn;
		logic [8:0] ramWrAddr;
		logic [7:0] ramWrData;
		logic [7:0] ctl1;
		logic headDir;
		logic clrOne;
		logic [2:0] ctl2;
		logic hostStrobe;
		logic wrPend;
		logic [7:0] wrAddr;
		logic [31:0] hrdata;
		logic hreadyout;
	} dmd_state_s;

endpackage : dmd_pkg

// ==== rtl/dmd_decoder.sv ====
// The register offsets and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module dmd_decoder
	import dmd_pkg::*;
#(
	parameter int DELAY_CYCLES = DELAY_CYCLES_DEF
)
(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	input wire logic [15:0] romWord,
	input wire logic [7:0] ramRdata,
	output logic [9:0] romAddr,
	output logic [8:0] ramAddr,
	output logic ramWrEn,
	output logic [8:0] ramWrAddr,
	output logic [7:0] ramWrData,
	output logic readGateOn,
	output logic writeGateOn,
	output logic headDirectionSelect,
	output logic crcPreset,
	output logic headStepPulse,
	output logic clearDriveTwo,
	output logic clearDriveOne,
	output logic selectDriveOne,
	output logic selectDriveTwo,
	output logic setDriveOne,
	output logic hostStrobe,
	output logic delayBusy
);

	// ****************************************
	// Helper functions
	// ****************************************

	// Mask test shared by all four mask branch groups
	function automatic logic maskHit(input logic [1:0] kind, input logic [3:0] nib,
		input logic [3:0] mask);
		logic hit;
		hit = 1'b0;
		case (kind)
			2'h0: hit = (nib == mask);
			2'h1: hit = (nib != mask);
			2'h2: hit = ((nib & mask) == mask);
			2'h3: hit = ((~nib & mask) == mask);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction : maskHit

	// ALU for register and immediate forms; returns carry out above the byte
	function automatic logic [8:0] aluOp(input logic [3:0] code, input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [8:0] r;
		r = 9'h000;
		case (code)
			OP_ADC: r = {1'b0, a} + {1'b0, b} + {8'h00, cin};
			OP_OR: r = {1'b0, a | b};
			OP_XOR: r = {1'b0, a ^ b};
			OP_ADD: r = {1'b0, a} + {1'b0, b};
			OP_AND: r = {1'b0, a & b};
			default: r = {1'b0, a};
		endcase
		return r;
	endfunction : aluOp

	// ****************************************
	// State and next state
	// ****************************************
	dmd_state_s s;
	dmd_state_s next_s;
	logic exec;
	logic [7:0] op;
	logic [7:0] opnd;
	logic [1:0] sel;
	logic [1:0] idc;
	logic [7:0] cur;
	logic [8:0] alu;
	logic [3:0] nib;
	logic accept;

	// Field split of the word on the ROM port
	assign op = romWord[15:8];
	assign opnd = romWord[7:0];
	assign sel = romWord[9:8];
	assign idc = romWord[11:10];
	assign cur = s.wreg[sel];
	assign nib = romWord[10] ? cur[7:4] : cur[3:0];
	assign accept = hsel & htrans[1] & hready;
	// A bus write in its data phase holds off the step so software setup never races it
	assign exec = (s.run | s.stepReq) & ~s.delayBusy & ~s.wrPend;

	// Instruction execution, delay timer and bus slave in one pass
	always_comb
	begin
		next_s = s;
		next_s.ramWrEn = 1'b0;
		next_s.ctl1 = 8'h00;
		next_s.clrOne = 1'b0;
		next_s.ctl2 = 3'h0;
		next_s.hostStrobe = 1'b0;
		next_s.wrPend = 1'b0;
		next_s.hrdata = 32'h0;
		next_s.hreadyout = 1'b1;
		alu = 9'h000;
		// Delay counts down; sequencing halts until it expires
		if (s.delayBusy)
		begin
			if (s.delayCnt == 20'h0)
				next_s.delayBusy = 1'b0;
			else
				next_s.delayCnt = s.delayCnt - 20'h1;
		end
		if (exec)
		begin
			next_s.stepReq = 1'b0;
			next_s.ic = s.ic + 10'h1;
			case (op[7:4])
				// Register category; 0x0 is the filler that only advances
				OP_B2M, OP_M2B, OP_ADC, OP_OR, OP_XOR, OP_ADD, OP_AND:
				begin
					alu = aluOp(op[7:4], cur, ramRdata, s.carry);
					if (!(op[7:4] <= OP_M2B && idc == ID_REG))
					begin
						if (idc == ID_REG)
							next_s.wreg[sel] = alu[7:0];
						else if (op[7:4] == OP_M2B)
							next_s.wreg[sel] = ramRdata;
						else
						begin
							next_s.ramWrEn = 1'b1;
							next_s.ramWrAddr = s.ptr;
							next_s.ramWrData = (op[7:4] == OP_B2M) ? cur : alu[7:0];
						end
						if (op[7:4] == OP_ADC || op[7:4] == OP_ADD)
							next_s.carry = alu[8];
						if (idc == ID_INC || idc == ID_REG)
							next_s.ptr = s.ptr + 9'h1;
						else if (idc == ID_DEC)
							next_s.ptr = s.ptr - 9'h1;
					end
				end
				4'h8:
				begin
					if (!op[3])
					begin
						if (maskHit(2'h0, nib, opnd[7:4]))
							next_s.ic = {s.ic[9:4], opnd[3:0]};
					end
					else if (!op[2])
						next_s.ic = {op[1:0], opnd};
					else if (op == OP_AUX_DATA || op == OP_AUX_WORK)
						next_s.ptr = {op[0], opnd};
				end
				4'h9, 4'ha, 4'hb:
				begin
					if (!op[3] && maskHit(op[5:4], nib, opnd[7:4]))
						next_s.ic = {s.ic[9:4], opnd[3:0]};
				end
				4'hc, 4'hd, 4'he, 4'hf:
				begin
					if (op[3:2] == 2'b10)
					begin
						alu = aluOp({2'b01, op[5:4]}, cur, opnd, 1'b0);
						next_s.wreg[sel] = alu[7:0];
						if (op[5:4] == 2'b10)
							next_s.carry = alu[8];
					end
					else if (op[3:2] == 2'b11 && op[5] == 1'b0)
					begin
						if ((cur == 8'h00) != op[4])
							next_s.ic = {s.ic[9:8], opnd};
					end
					else if (op == OP_CTRL1 || op == OP_CTRL1_CLR)
					begin
						// Each operand bit gates its own line; bits 2 and 3 stay dead
						next_s.ctl1 = opnd & 8'hf3;
						next_s.headDir = opnd[4];
						next_s.clrOne = op[0];
					end
					else if (op == OP_CTRL2)
					begin
						next_s.ctl2 = opnd[2:0];
						next_s.hostStrobe = opnd[4];
						if (opnd[5])
						begin
							next_s.delayBusy = 1'b1;
							next_s.delayCnt = 20'(DELAY_CYCLES - 1);
						end
					end
				end
				default:
				begin
				end
			endcase
		end
		// Bus data phase write; software load of the counter beats the step
		if (s.wrPend)
		begin
			case (s.wrAddr)
				OFS_CTRL:
				begin
					next_s.run = hwdata[CTRL_RUN_BIT];
					next_s.stepReq = s.stepReq | hwdata[CTRL_STEP_BIT];
				end
				OFS_WREGS: next_s.wreg = hwdata;
				OFS_ICLOAD:
				begin
					next_s.ic = hwdata[9:0];
					next_s.ptr = hwdata[STAT_PTR_LSB +: 9];
				end
				default:
				begin
				end
			endcase
		end
		// Address phase; read data is captured here, zero wait, unmapped reads zero
		if (accept)
		begin
			next_s.wrPend = hwrite;
			next_s.wrAddr = {haddr[7:2], 2'b00};
			if (!hwrite)
			begin
				case ({haddr[7:2], 2'b00})
					OFS_CTRL: next_s.hrdata = {30'h0, s.stepReq, s.run};
					OFS_STATUS: next_s.hrdata = {s.delayBusy, s.carry, 5'h0, s.ptr,
						6'h0, s.ic};
					OFS_WREGS: next_s.hrdata = s.wreg;
					OFS_ICLOAD: next_s.hrdata = {7'h0, s.ptr, 6'h0, s.ic};
					default: next_s.hrdata = 32'h0;
				endcase
			end
		end
	end

	// State register
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			s <= '0;
			s.ic <= IC_RST;
			s.ptr <= PTR_RST;
			s.hreadyout <= 1'b1;
		end
		else
			s <= next_s;
	end

	// ****************************************
	// Outputs, all straight from state flops except hresp, which is tied low
	// ****************************************
	assign hreadyout = s.hreadyout;
	assign hrdata = s.hrdata;
	assign hresp = 1'b0;
	assign romAddr = s.ic;
	assign ramAddr = s.ptr;
	assign ramWrEn = s.ramWrEn;
	assign ramWrAddr = s.ramWrAddr;
	assign ramWrData = s.ramWrData;
	assign readGateOn = s.ctl1[0];
	assign writeGateOn = s.ctl1[1];
	assign headDirectionSelect = s.headDir;
	assign crcPreset = s.ctl1[5];
	assign headStepPulse = s.ctl1[6];
	assign clearDriveTwo = s.ctl1[7];
	assign clearDriveOne = s.clrOne;
	assign selectDriveOne = s.ctl2[0];
	assign selectDriveTwo = s.ctl2[1];
	assign setDriveOne = s.ctl2[2];
	assign hostStrobe = s.hostStrobe;
	assign delayBusy = s.delayBusy;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	sequence seqDelayStart;
		exec && op == OP_CTRL2 && opnd[5];
	endsequence
	// Counter must freeze for the first two cycles of the delay; software leaves the counter alone meanwhile
	sequence seqHeld;
		delayBusy ##1 (delayBusy && $stable(romAddr)) [* 2];
	endsequence

	AST_UNCOND: assert property (exec && op[7:2] == 6'b100010 && !s.wrPend
		|=> romAddr == $past(romWord[9:0]))
		else $error("unconditional branch target wrong");
	// An untaken mask branch may carry into bit 4, so only a plain advance is also legal
	AST_MASK_HI: assert property (exec && op[7:6] == 2'b10 && !op[3]
		|=> romAddr[9:4] == $past(s.ic[9:4]) || romAddr == $past(s.ic) + 10'h1)
		else $error("mask branch disturbed upper counter bits");
	AST_BRZ_MISS: assert property (exec && op[7:2] == 6'b110011 && cur != 8'h00
		|=> romAddr == $past(s.ic) + 10'h1)
		else $error("untaken zero branch did not advance");
	AST_AUX: assert property (exec && op == OP_AUX_WORK
		|=> ramAddr == {1'b1, $past(opnd)})
		else $error("work buffer preset wrong");
	AST_CTL1: assert property (exec && op == OP_CTRL1
		|=> readGateOn == $past(opnd[0]) && writeGateOn == $past(opnd[1])
		&& crcPreset == $past(opnd[5]) ##1 ($past(exec) || (!readGateOn && !crcPreset)))
		else $error("control one gate pulses wrong");
	AST_HEAD: assert property (exec && op == OP_CTRL1
		|=> headStepPulse == $past(opnd[6]) && headDirectionSelect == $past(opnd[4]))
		else $error("head lines wrong");
	AST_CLR: assert property (exec && op == OP_CTRL1_CLR
		|=> clearDriveOne && clearDriveTwo == $past(opnd[7]))
		else $error("drive clear wrong");
	AST_CTL2: assert property (exec && op == OP_CTRL2
		|=> {setDriveOne, selectDriveTwo, selectDriveOne} == $past(opnd[2:0])
		&& hostStrobe == $past(opnd[4]))
		else $error("control two outputs wrong");
	AST_DELAY: assert property (seqDelayStart |=> seqHeld)
		else $error("delay did not hold sequencing");
	AST_PTR_INC: assert property (exec && op[7:4] >= OP_ADC && op[7:4] <= OP_AND
		&& idc == ID_INC |=> ramAddr == $past(s.ptr) + 9'h1 && ramWrEn)
		else $error("pointer increment or RAM write missing");
	AST_NOOP: assert property (exec && op == 8'h00
		|=> !ramWrEn && $stable(s.wreg) && $stable(ramAddr))
		else $error("no-operation changed state");
	AST_TRUE: assert property (exec && op[7:4] == 4'ha && !op[3]
		&& (nib & opnd[7:4]) == opnd[7:4] |=> romAddr[3:0] == $past(opnd[3:0]))
		else $error("true branch not taken");
	// Transfers carrying the register-result code must leave RAM, registers and pointer alone
	AST_XFER_REFUSE: assert property (exec && (op[7:4] == OP_B2M || op[7:4] == OP_M2B)
		&& idc == ID_REG |=> !ramWrEn && $stable(s.wreg) && $stable(ramAddr))
		else $error("transfer with register code not refused");
	AST_STORE_DEC: assert property (exec && op[7:4] == OP_B2M && idc == ID_DEC
		|=> ramWrEn && ramWrAddr == $past(s.ptr) && ramWrData == $past(cur)
		&& ramAddr == $past(s.ptr) - 9'h1)
		else $error("store then decrement wrong");

endmodule : dmd_decoder

// ==== tb/dmd_store_model.sv ====
`timescale 1ns/1ps
module dmd_store_model
(
	input wire logic clk_sys,
	input wire logic [9:0] romAddr,
	output logic [15:0] romWord,
	input wire logic [8:0] ramAddr,
	output logic [7:0] ramRdata,
	input wire logic ramWrEn,
	input wire logic [8:0] ramWrAddr,
	input wire logic [7:0] ramWrData
);
	logic [15:0] rom [1024];
	logic [7:0] ram [512];
	// Seed buffer bytes so that reads are nonzero except at addresses 145 and 401
	initial
	begin
		for (int i = 0; i < 1024; i++) rom[i] = 16'h0000;
		for (int i = 0; i < 512; i++) ram[i] = 8'(i * 37 + 11);
	end
	// Word and byte follow their addresses with no latency
	assign romWord = rom[romAddr];
	assign ramRdata = ram[ramAddr];
	// A strobed byte lands at the edge
	always @(posedge clk_sys)
	begin
		if (ramWrEn === 1'b1)
			ram[ramWrAddr] <= ramWrData;
	end
endmodule : dmd_store_model

// ==== tb/tb_disk_microinstruction_decoder.sv ====
`timescale 1ns/1ps
module tb_disk_microinstruction_decoder;
	import dmd_pkg::*;
	localparam int DLY = 8;
	logic clk_sys, nrst, hsel, hwrite, hreadyout, hresp, ramWrEn, delayBusy;
	logic readGateOn, writeGateOn, headDirectionSelect, crcPreset, headStepPulse;
	logic clearDriveTwo, clearDriveOne, selectDriveOne, selectDriveTwo, setDriveOne, hostStrobe;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [15:0] romWord;
	logic [7:0] ramRdata, ramWrData;
	logic [9:0] romAddr, eIc, sticky, ePulse;
	logic [8:0] ramAddr, ramWrAddr, ePtr;
	logic [17:0] wrSeen, eWrite;
	logic [7:0] eReg [4];
	logic [7:0] eRam [512];
	logic eCarry, eDir, eDel;
	int fail_count, checked, cyc;
	integer seed;
	wire logic hready = hreadyout;

	dmd_decoder #(.DELAY_CYCLES(DLY)) dmd_decoder_i (.clk_sys(clk_sys), .nrst(nrst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .romWord(romWord), .ramRdata(ramRdata), .romAddr(romAddr),
		.ramAddr(ramAddr), .ramWrEn(ramWrEn), .ramWrAddr(ramWrAddr), .ramWrData(ramWrData),
		.readGateOn(readGateOn), .writeGateOn(writeGateOn),
		.headDirectionSelect(headDirectionSelect), .crcPreset(crcPreset),
		.headStepPulse(headStepPulse), .clearDriveTwo(clearDriveTwo),
		.clearDriveOne(clearDriveOne), .selectDriveOne(selectDriveOne),
		.selectDriveTwo(selectDriveTwo), .setDriveOne(setDriveOne),
		.hostStrobe(hostStrobe), .delayBusy(delayBusy));
	dmd_store_model dmd_store_model_i (.clk_sys(clk_sys), .romAddr(romAddr),
		.romWord(romWord), .ramAddr(ramAddr), .ramRdata(ramRdata), .ramWrEn(ramWrEn),
		.ramWrAddr(ramWrAddr), .ramWrData(ramWrData));

	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// Latch at the falling edge so a one-cycle strobe is never missed
	always @(negedge clk_sys)
	begin
		sticky = sticky | {readGateOn, writeGateOn, crcPreset, headStepPulse, clearDriveTwo,
			clearDriveOne, selectDriveOne, selectDriveTwo, setDriveOne, hostStrobe};
		if (ramWrEn === 1'b1)
			wrSeen = {ramWrAddr, ramWrData, 1'b1};
	end
	// Watchdog cuts a hung handshake short
	always @(posedge clk_sys)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fail_count++;
			complete_run();
		end
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic complete_run();
		$display("Counts: %0d mismatches, %0d checks", fail_count, checked);
		if (fail_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	// Single word transfer; request held until the slave is ready
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	// Reference behaviour of one instruction on the expected state
	function automatic void model(input logic [15:0] w);
		logic [7:0] h, o, b, m, res;
		logic [3:0] nb, mk;
		logic [8:0] s;
		logic [9:0] ic0;
		logic t;
		h = w[15:8];
		o = w[7:0];
		b = eReg[h[1:0]];
		m = eRam[ePtr];
		nb = h[2] ? b[7:4] : b[3:0];
		mk = o[7:4];
		s = {1'b0, b} + {1'b0, (h[7:6] == 2'h3) ? o : m} + {8'h0, (h[7:4] == 4'h3) & eCarry};
		ic0 = eIc;
		eIc = eIc + 10'h1;
		case (h[5:4])
			2'h0: t = (nb == mk);
			2'h1: t = (nb != mk);
			2'h2: t = ((nb & mk) == mk);
			default: t = ((~nb & mk) == mk);
		endcase
		if (h[7:4] inside {[4'h1:4'h7]} && !(h[7:4] < 4'h3 && h[3:2] == 2'h3))
		begin
			case (h[7:4])
				4'h1: res = b;
				4'h2: res = m;
				4'h4: res = b | m;
				4'h5: res = b ^ m;
				4'h7: res = b & m;
				default: res = s[7:0];
			endcase
			if (h[7:4] == 4'h3 || h[7:4] == 4'h6)
				eCarry = s[8];
			if (h[7:4] == 4'h2 || h[3:2] == 2'h3)
				eReg[h[1:0]] = res;
			else
			begin
				eWrite = {ePtr, res, 1'b1};
				eRam[ePtr] = res;
			end
			if (h[3:2] == 2'h2)
				ePtr = ePtr - 9'h1;
			else if (h[3:2] != 2'h0)
				ePtr = ePtr + 9'h1;
		end
		else if (h[7:6] == 2'h3 && h[3:2] == 2'h2)
		begin
			case (h[5:4])
				2'h0: eReg[h[1:0]] = b | o;
				2'h1: eReg[h[1:0]] = b ^ o;
				2'h2: eReg[h[1:0]] = s[7:0];
				default: eReg[h[1:0]] = b & o;
			endcase
			if (h[5:4] == 2'h2)
				eCarry = s[8];
		end
		else if (h[7:5] == 3'h6 && h[3:2] == 2'h3 && ((b == 8'h0) != h[4]))
			eIc = {ic0[9:8], o};
		else if (h[7:6] == 2'h2 && !h[3] && t)
			eIc = {ic0[9:4], o[3:0]};
		else if (h[7:2] == 6'h22)
			eIc = {h[1:0], o};
		else if (h[7:1] == 7'h46)
			ePtr = {h[0], o};
		else if (h[7:1] == 7'h76)
		begin
			ePulse = {o[0], o[1], o[5], o[6], o[7], h[0], 4'h0};
			eDir = o[4];
		end
		else if (h == OP_CTRL2)
		begin
			ePulse = {6'h0, o[0], o[1], o[2], o[4]};
			eDel = o[5];
		end
	endfunction : model

	// Place one word at a chosen step, single-step it, then compare all state
	task automatic exec(input logic [15:0] w, input logic [9:0] ic, input logic [8:0] ptr,
		input logic [31:0] regs);
		logic [31:0] rd;
		int n;
		eIc = ic;
		ePtr = ptr;
		eDel = 1'b0;
		eWrite = 18'h0;
		ePulse = 10'h0;
		{eReg[3], eReg[2], eReg[1], eReg[0]} = regs;
		dmd_store_model_i.rom[ic] = w;
		bus(1'b1, OFS_ICLOAD, {7'h0, ptr, 6'h0, ic}, rd);
		bus(1'b1, OFS_WREGS, regs, rd);
		sticky = 10'h0;
		wrSeen = 18'h0;
		bus(1'b1, OFS_CTRL, 32'h1 << CTRL_STEP_BIT, rd);
		repeat (3) @(posedge clk_sys);
		model(w);
		check({31'h0, delayBusy}, {31'h0, eDel});
		n = 0;
		while (delayBusy === 1'b1 && n < 20)
		begin
			@(posedge clk_sys);
			n++;
		end
		// Two busy edges have passed before the count starts
		check(32'(n), eDel ? 32'(DLY - 1) : 32'h0);
		check({22'h0, sticky}, {22'h0, ePulse});
		check({31'h0, headDirectionSelect}, {31'h0, eDir});
		check({14'h0, wrSeen}, {14'h0, eWrite});
		bus(1'b0, OFS_STATUS, 32'h0, rd);
		check({22'h0, rd[9:0]}, {22'h0, eIc});
		check({22'h0, rd[30], rd[24:16]}, {22'h0, eCarry, ePtr});
		bus(1'b0, OFS_WREGS, 32'h0, rd);
		check(rd, {eReg[3], eReg[2], eReg[1], eReg[0]});
	endtask : exec

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		logic [31:0] rd, regs;
		logic [7:0] lo;
		seed = 32'h3de2;
		{nrst, hsel, haddr, htrans, hwrite, hwdata} = '0;
		hsize = 3'h2;
		{fail_count, checked, cyc} = '0;
		{sticky, wrSeen, eCarry, eDir} = '0;
		for (int i = 0; i < 512; i++) eRam[i] = 8'(i * 37 + 11);
		repeat (2) @(posedge clk_sys);
		nrst <= 1'b1;
		@(posedge clk_sys);
		#1 check({11'h0, hresp, hreadyout, romAddr, ramAddr}, 32'h80000);
		bus(1'b0, 8'h10, 32'h0, rd);
		check(rd, 32'h0);
		// Hand-picked boundaries: mask hits, counter and pointer wrap
		exec(16'h805a, 10'h007, 9'h000, 32'h5);
		exec(16'h8426, 10'h107, 9'h000, 32'h20);
		exec(16'h0000, 10'h3ff, 9'h1ff, 32'h0);
		exec(16'h1800, 10'h010, 9'h000, 32'h77);
		// Every high byte in four passes, the last three with registers biased toward taken branches
		for (int p = 0; p < 4; p++)
			for (int k = 0; k < 256; k++)
			begin
				lo = 8'($random(seed));
				regs = $random(seed);
				if (p != 0)
					regs[8 * (k % 4) +: 8] = (p == 1) ? {lo[7:4], lo[7:4]} :
						(p == 2) ? {~lo[7:4], ~lo[7:4]} : 8'h0;
				exec({8'(k), lo}, 10'($random(seed)), 9'($random(seed)), regs);
			end
		// Free run: one immediate step, then a self-loop that software stops
		dmd_store_model_i.rom[10'h200] = 16'hc805;
		dmd_store_model_i.rom[10'h201] = 16'h8a01;
		bus(1'b1, OFS_WREGS, 32'h0, rd);
		bus(1'b1, OFS_ICLOAD, 32'h200, rd);
		bus(1'b1, OFS_CTRL, 32'h1 << CTRL_RUN_BIT, rd);
		repeat (5) @(posedge clk_sys);
		bus(1'b0, OFS_CTRL, 32'h0, rd);
		check(rd, 32'h1 << CTRL_RUN_BIT);
		bus(1'b1, OFS_CTRL, 32'h0, rd);
		bus(1'b0, OFS_ICLOAD, 32'h0, rd);
		check(rd, 32'h201);
		bus(1'b0, OFS_WREGS, 32'h0, rd);
		check(rd, 32'h5);
		complete_run();
	end
endmodule : tb_disk_microinstruction_decoder
